/* inc/bsdr_map.svh */
// register map, field positions, reset values and timing counts
`ifndef BSDR_MAP_SVH
`define BSDR_MAP_SVH

// register group base and boot/route register offset
`define BSDR_BASE           32'h4001_0000
`define BSDR_CFG_OFS        32'h0000_0000
`define BSDR_CFG_ADDR       (`BSDR_BASE + `BSDR_CFG_OFS)

// field positions inside the boot/route register
`define BSDR_BOOT_MODE_LSB  0
`define BSDR_BOOT_MODE_MSB  1
`define BSDR_CONV_SEL_BIT   8
`define BSDR_STX_SEL_BIT    9
`define BSDR_SRX_SEL_BIT    10
`define BSDR_TMB_SEL_BIT    11
`define BSDR_TMC_SEL_BIT    12
`define BSDR_HDRV_BIT       19

// writable bits and reset values
`define BSDR_CFG_WMASK      32'h0008_1f00
`define BSDR_CFG_RST        32'h0000_0000
`define BSDR_BOOT_RST       2'h0

// boot strap capture: edge number after reset release
`define BSDR_LATCH_EDGE     3'h4

// boot alias window and original memory bases
`define BSDR_ALIAS_MASK     32'hf800_0000
`define BSDR_ALIAS_BASE     32'h0000_0000
`define BSDR_FLASH_BASE     32'h0800_0000
`define BSDR_SYSMEM_BASE    32'h1fff_ec00

`endif

/* inc/bsdr_pkg.sv */
// types shared by the boot select and dma route block
package bsdr_pkg;

   // boot source chosen from the two boot select bits
   typedef enum logic [1:0] {
      BSDR_SRC_FLASH,
      BSDR_SRC_SYSMEM,
      BSDR_SRC_SRAM
   } bsdr_boot_src_t;

   // number of dma request channels fed by the router
   typedef logic [4:0] bsdr_dma_vec_t;

endpackage

/* core/bsdr_cfg.sv */
// boot select latch, boot alias and dma request routing register
//
// Operation
// - pin level captured on fourth rising clock edge after reset, then held.
// - pin low boots flash; 01 boots system memory; 11 boots sram.
// - boot field bit0 is latched pin, bit1 is inverted option bit.
// - chosen flash or system memory also answers at boot space from zero.
// - bit 19 enables pin high drive and bypasses its speed control.
// - bit 12 routes third timer requests to channel 0 or 1.
// - bit 11 routes second timer requests to channel 2 or 3.
// - bit 10 routes serial receive requests to channel 2 or 4.
// - bit 9 routes serial transmit requests to channel 1 or 3.
// - bit 8 routes converter requests to channel 0 or 1.
// - reset clears writable fields; boot bits follow pin and option.
// - register decoded at base 0x40010000, offset 0x00.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`include "bsdr_map.svh"

module bsdr_cfg
(
   input  wire logic                    ref_clk_i,
   input  wire logic                    rst_b_i,
   input  wire logic [31:0]             reg_addr_i,
   input  wire logic [31:0]             reg_wdata_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   output logic      [31:0]             reg_rdata_o,
   input  wire logic                    boot_pin_primary_i,
   input  wire logic                    boot_option_inverted_i,
   output logic      [1:0]              boot_mode_o,
   output bsdr_pkg::bsdr_boot_src_t     boot_src_o,
   output logic                         boot_latched_o,
   input  wire logic [31:0]             cpu_addr_i,
   output logic      [31:0]             mem_addr_o,
   output logic                         pin_high_drive_enable_o,
   output logic                         pin_speed_bypass_o,
   input  wire logic                    timer_c_req_i,
   input  wire logic                    timer_b_req_i,
   input  wire logic                    serial_rx_req_i,
   input  wire logic                    serial_tx_req_i,
   input  wire logic                    converter_req_i,
   output bsdr_pkg::bsdr_dma_vec_t      dma_ch_req_o
);
   import bsdr_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // state
   logic [31:0]     cfg_r;
   logic [31:0]     cfg_nxt;
   logic [2:0]      edge_cnt_r;
   logic            latched_r;
   logic [1:0]      boot_mode_r;
   bsdr_boot_src_t  boot_src_r;
   bsdr_boot_src_t  boot_src_nxt;
   logic [31:0]     rdata_r;
   logic [31:0]     mem_addr_r;
   bsdr_dma_vec_t   dma_r;

   ////////////////////////////////////////////////////////////////////
   // register decode
   wire        cfg_hit    = (reg_addr_i == `BSDR_CFG_ADDR);
   wire        cfg_wr     = reg_wr_i & cfg_hit;
   wire        cfg_rd     = reg_rd_i & cfg_hit;
   // only the writable fields take write data; boot bits are never written
   assign cfg_nxt = cfg_wr ? (reg_wdata_i & `BSDR_CFG_WMASK) : cfg_r;
   // reserved bits come out as zero, boot bits from the strap latch
   wire [31:0] cfg_view   = (cfg_r & `BSDR_CFG_WMASK) | {30'h0, boot_mode_r};
   // unmapped reads answer zero
   wire [31:0] rdata_nxt  = cfg_rd ? cfg_view : 32'h0;

   // writable fields, cleared by reset
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         cfg_r <= `BSDR_CFG_RST;
      else
         cfg_r <= cfg_nxt;
   end

   // read data valid only in the cycle after the read strobe
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         rdata_r <= 32'h0;
      else
         rdata_r <= rdata_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // boot strap capture
   // the pin is sampled late so that it settles after reset release
   wire        latch_now  = !latched_r && (edge_cnt_r == (`BSDR_LATCH_EDGE - 3'h1));
   wire [1:0]  boot_cap   = {~boot_option_inverted_i, boot_pin_primary_i};

   // count edges after release; reset itself takes only constants
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
      begin
         edge_cnt_r  <= 3'h0;
         latched_r   <= 1'b0;
         boot_mode_r <= `BSDR_BOOT_RST;
      end
      else if (latch_now)
      begin
         latched_r   <= 1'b1;
         boot_mode_r <= boot_cap;
      end
      else if (!latched_r)
         edge_cnt_r  <= edge_cnt_r + 3'h1;
   end

   ////////////////////////////////////////////////////////////////////
   // boot source selection
   // pin low wins whatever the option bit says
   always_comb
   begin
      case (boot_mode_r)
         2'h1:    boot_src_nxt = BSDR_SRC_SYSMEM;
         2'h3:    boot_src_nxt = BSDR_SRC_SRAM;
         default: boot_src_nxt = BSDR_SRC_FLASH;
      endcase
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         boot_src_r <= BSDR_SRC_FLASH;
      else
         boot_src_r <= boot_src_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // boot space alias
   // sram boot is left unaliased: software relocates its vector table
   wire        in_alias   = ((cpu_addr_i & `BSDR_ALIAS_MASK) == `BSDR_ALIAS_BASE);
   wire [31:0] flash_addr = `BSDR_FLASH_BASE + cpu_addr_i;
   wire [31:0] sys_addr   = `BSDR_SYSMEM_BASE + cpu_addr_i;
   wire [31:0] alias_addr =
      (boot_src_r == BSDR_SRC_FLASH)  ? flash_addr :
      (boot_src_r == BSDR_SRC_SYSMEM) ? sys_addr   : cpu_addr_i;
   wire [31:0] mem_nxt    = in_alias ? alias_addr : cpu_addr_i;

   // one cycle of latency keeps the output on a flop
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         mem_addr_r <= 32'h0;
      else
         mem_addr_r <= mem_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // dma request routing
   wire sel_tmc  = cfg_r[`BSDR_TMC_SEL_BIT];
   wire sel_tmb  = cfg_r[`BSDR_TMB_SEL_BIT];
   wire sel_srx  = cfg_r[`BSDR_SRX_SEL_BIT];
   wire sel_stx  = cfg_r[`BSDR_STX_SEL_BIT];
   wire sel_conv = cfg_r[`BSDR_CONV_SEL_BIT];

   // each source lands on its default or alternate channel
   wire [4:0] to_tmc  = sel_tmc  ? {3'h0, timer_c_req_i, 1'b0}
                                 : {4'h0, timer_c_req_i};
   wire [4:0] to_tmb  = sel_tmb  ? {1'b0, timer_b_req_i, 3'h0}
                                 : {2'h0, timer_b_req_i, 2'h0};
   wire [4:0] to_srx  = sel_srx  ? {serial_rx_req_i, 4'h0}
                                 : {2'h0, serial_rx_req_i, 2'h0};
   wire [4:0] to_stx  = sel_stx  ? {1'b0, serial_tx_req_i, 3'h0}
                                 : {3'h0, serial_tx_req_i, 1'b0};
   wire [4:0] to_conv = sel_conv ? {3'h0, converter_req_i, 1'b0}
                                 : {4'h0, converter_req_i};
   // shared channels simply merge; the dma side arbitrates by source
   wire [4:0] dma_nxt = to_tmc | to_tmb | to_srx | to_stx | to_conv;

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         dma_r <= 5'h0;
      else
         dma_r <= dma_nxt;
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign reg_rdata_o             = rdata_r;
   assign boot_mode_o             = boot_mode_r;
   assign boot_src_o              = boot_src_r;
   assign boot_latched_o          = latched_r;
   assign mem_addr_o              = mem_addr_r;
   assign pin_high_drive_enable_o = cfg_r[`BSDR_HDRV_BIT];
   assign pin_speed_bypass_o      = cfg_r[`BSDR_HDRV_BIT];
   assign dma_ch_req_o            = dma_r;

   ////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   // strap stays open for four edges after release, then closes
   sequence s_wait_strap;
      !latched_r [*4];
   endsequence
   sequence s_strap_closed;
      latched_r && (boot_mode_r[0] == $past(boot_pin_primary_i));
   endsequence
   property p_strap_edge;
      $rose(rst_b_i) |-> s_wait_strap ##1 s_strap_closed;
   endproperty
   a_strap_edge: assert property (p_strap_edge) else $error("pin not taken on edge 4");

   property p_strap_hold;
      latched_r |=> $stable(boot_mode_r);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("boot mode moved");

   property p_src_pick;
      latched_r |=> ##1 (boot_src_r == (!boot_mode_r[0] ? BSDR_SRC_FLASH :
                          boot_mode_r[1] ? BSDR_SRC_SRAM : BSDR_SRC_SYSMEM));
   endproperty
   a_src_pick: assert property (p_src_pick) else $error("wrong boot source");

   property p_mode_bit1;
      latch_now |=> (boot_mode_r[1] == !$past(boot_option_inverted_i));
   endproperty
   a_mode_bit1: assert property (p_mode_bit1) else $error("bit1 not inverted option");

   property p_alias_flash;
      (boot_src_r == BSDR_SRC_FLASH) && in_alias |=>
         mem_addr_r == `BSDR_FLASH_BASE + $past(cpu_addr_i);
   endproperty
   a_alias_flash: assert property (p_alias_flash) else $error("flash alias wrong");

   property p_alias_sys;
      (boot_src_r == BSDR_SRC_SYSMEM) && in_alias |=>
         mem_addr_r == `BSDR_SYSMEM_BASE + $past(cpu_addr_i);
   endproperty
   a_alias_sys: assert property (p_alias_sys) else $error("system memory alias wrong");

   // sram boot passes every address through untouched
   property p_alias_sram;
      (boot_src_r == BSDR_SRC_SRAM) |=> mem_addr_r == $past(cpu_addr_i);
   endproperty
   a_alias_sram: assert property (p_alias_sram) else $error("sram boot address changed");

   property p_hdrv;
      cfg_wr |=> pin_high_drive_enable_o == $past(reg_wdata_i[`BSDR_HDRV_BIT])
                 && pin_speed_bypass_o == pin_high_drive_enable_o;
   endproperty
   a_hdrv: assert property (p_hdrv) else $error("high drive not following write");

   property p_route_tmc;
      timer_c_req_i |=> ($past(sel_tmc) ? dma_ch_req_o[1] : dma_ch_req_o[0]);
   endproperty
   a_route_tmc: assert property (p_route_tmc) else $error("third timer misrouted");

   property p_route_tmb;
      timer_b_req_i |=> ($past(sel_tmb) ? dma_ch_req_o[3] : dma_ch_req_o[2]);
   endproperty
   a_route_tmb: assert property (p_route_tmb) else $error("second timer misrouted");

   property p_route_srx;
      serial_rx_req_i |=> ($past(sel_srx) ? dma_ch_req_o[4] : dma_ch_req_o[2]);
   endproperty
   a_route_srx: assert property (p_route_srx) else $error("serial rx misrouted");

   property p_route_stx;
      serial_tx_req_i |=> ($past(sel_stx) ? dma_ch_req_o[3] : dma_ch_req_o[1]);
   endproperty
   a_route_stx: assert property (p_route_stx) else $error("serial tx misrouted");

   property p_route_conv;
      converter_req_i |=> ($past(sel_conv) ? dma_ch_req_o[1] : dma_ch_req_o[0]);
   endproperty
   a_route_conv: assert property (p_route_conv) else $error("converter misrouted");

   property p_reset_clear;
      $rose(rst_b_i) |-> (cfg_r == 32'h0) && (dma_ch_req_o == 5'h0);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("fields not cleared");

   property p_decode;
      reg_rd_i && !cfg_hit |=> reg_rdata_o == 32'h0;
   endproperty
   a_decode: assert property (p_decode) else $error("unmapped read not zero");

   // read data stand only for the cycle after a read strobe
   property p_rdata_idle;
      !reg_rd_i |=> reg_rdata_o == 32'h0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

   property p_read_view;
      cfg_rd |=> reg_rdata_o == ((cfg_r & `BSDR_CFG_WMASK) | {30'h0, boot_mode_r});
   endproperty
   a_read_view: assert property (p_read_view) else $error("read value wrong");

   property p_reserved;
      cfg_wr && !latch_now |=> (cfg_r & ~`BSDR_CFG_WMASK) == 32'h0 && $stable(boot_mode_r);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bit stored");

endmodule

/* verification/bsdr_cpu_model.sv */
// partner model: processor boot fetch sequence into the alias port
`timescale 1ns/1ps

module bsdr_cpu_model
(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        boot_latched_i,
   output logic      [31:0] cpu_addr_o
);
   logic [1:0] step_r;

   ////////////////////////////////////////////////////////////////////////////////
   // waits for the strap so the first fetch already sees the chosen alias
   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_b_i)
         step_r <= 2'h0;
      else if (boot_latched_i && step_r != 2'h2)
         step_r <= step_r + 2'h1;
   end

   // stack pointer at zero first, then start address at four, then held
   assign cpu_addr_o = (step_r == 2'h2) ? 32'h0000_0004 : 32'h0000_0000;
endmodule

/* verification/bsdr_cfg_tb.sv */
// self-checking bench for the boot select and dma route register
`timescale 1ns/1ps
`include "bsdr_map.svh"

module bsdr_cfg_tb;
   import bsdr_pkg::*;
   logic           clk = 1'b0;
   logic           rst_b = 1'b0;
   logic    [31:0] addr = 32'h0;
   logic    [31:0] wdata = 32'h0;
   logic           wr = 1'b0;
   logic           rd = 1'b0;
   logic           pin = 1'b0;
   logic           opt = 1'b0;
   logic     [4:0] req_v = 5'h0;
   logic    [31:0] rdata;
   logic    [31:0] cpu_addr;
   logic    [31:0] mem_addr;
   logic     [1:0] mode;
   bsdr_boot_src_t src;
   logic           latched;
   logic           hdrv;
   logic           byp;
   bsdr_dma_vec_t  dma;
   int             error_cnt = 0;
   int             checks_done = 0;
   int             ch_clr[5] = '{0, 2, 2, 1, 0};
   int             ch_set[5] = '{1, 3, 4, 3, 1};

   always #20 clk = ~clk;

   bsdr_cfg DUT (.ref_clk_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .boot_pin_primary_i(pin),
      .boot_option_inverted_i(opt), .boot_mode_o(mode), .boot_src_o(src),
      .boot_latched_o(latched), .cpu_addr_i(cpu_addr), .mem_addr_o(mem_addr),
      .pin_high_drive_enable_o(hdrv), .pin_speed_bypass_o(byp), .timer_c_req_i(req_v[4]),
      .timer_b_req_i(req_v[3]), .serial_rx_req_i(req_v[2]), .serial_tx_req_i(req_v[1]),
      .converter_req_i(req_v[0]), .dma_ch_req_o(dma));

   bsdr_cpu_model cpu (.ref_clk_i(clk), .rst_b_i(rst_b), .boot_latched_i(latched),
      .cpu_addr_o(cpu_addr));

   ////////////////////////////////////////////////////////////////////////////////
   // shared compare, bus cycles and verdict
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic final_report();
      if (error_cnt == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // strap capture, boot source, alias and reset value for one strap setting
   task automatic boot_case(input logic p, input logic o, input logic [1:0] em,
                            input bsdr_boot_src_t es, input logic [31:0] eb);
      logic [31:0] d;
      @(posedge clk);
      rst_b <= 1'b0;
      pin <= p;
      opt <= o;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      #1 chk("latched early", {31'h0, latched}, 32'h0);
      @(posedge clk);
      #1 chk("latched", {31'h0, latched}, 32'h1);
      chk("boot mode", {30'h0, mode}, {30'h0, em});
      pin <= ~p;
      @(posedge clk);
      #1 chk("boot src", {30'h0, src}, {30'h0, es});
      @(posedge clk);
      #1 chk("stack fetch", mem_addr, eb);
      @(posedge clk);
      #1 chk("vector fetch", mem_addr, eb + 32'h4);
      rd_reg(`BSDR_CFG_ADDR, d);
      chk("cfg after reset", d, {30'h0, em});
      chk("mode held", {30'h0, mode}, {30'h0, em});
      chk("drive after reset", {31'h0, hdrv}, 32'h0);
   endtask

   // writable mask, read-only bits, unmapped place, high drive
   task automatic reg_case(input logic [1:0] em);
      logic [31:0] d;
      wr_reg(`BSDR_CFG_ADDR, 32'hffff_ffff);
      #1 chk("high drive", {30'h0, hdrv, byp}, 32'h3);
      wr_reg(`BSDR_CFG_ADDR + 32'h4, 32'h0);
      rd_reg(`BSDR_CFG_ADDR + 32'h4, d);
      chk("unmapped read", d, 32'h0);
      rd_reg(`BSDR_CFG_ADDR, d);
      chk("cfg all ones", d, 32'h0008_1f00 | {30'h0, em});
      @(posedge clk);
      #1 chk("read data cleared", rdata, 32'h0);
      wr_reg(`BSDR_CFG_ADDR, 32'h0);
      #1 chk("high drive off", {30'h0, hdrv, byp}, 32'h0);
   endtask

   // each source with its select clear and set, then all sources at once
   task automatic dma_case();
      logic [31:0] e;
      for (int i = 0; i < 5; i++)
         for (int s = 0; s < 2; s++)
         begin
            wr_reg(`BSDR_CFG_ADDR, (s == 1) ? (32'h1 << (12 - i)) : 32'h0);
            req_v <= 5'h1 << (4 - i);
            @(posedge clk);
            @(posedge clk);
            e = 32'h1 << ((s == 1) ? ch_set[i] : ch_clr[i]);
            #1 chk("dma route", {27'h0, dma}, e);
            req_v <= 5'h0;
         end
      wr_reg(`BSDR_CFG_ADDR, 32'h0);
      req_v <= 5'h1f;
      @(posedge clk);
      @(posedge clk);
      #1 chk("dma shared", {27'h0, dma}, 32'h7);
      req_v <= 5'h0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence, and a guard against a hung run
   initial
   begin
      boot_case(1'b0, 1'b0, 2'b10, BSDR_SRC_FLASH, 32'h0800_0000);
      reg_case(2'b10);
      dma_case();
      boot_case(1'b1, 1'b1, 2'b01, BSDR_SRC_SYSMEM, 32'h1fff_ec00);
      boot_case(1'b1, 1'b0, 2'b11, BSDR_SRC_SRAM, 32'h0);
      boot_case(1'b0, 1'b1, 2'b00, BSDR_SRC_FLASH, 32'h0800_0000);
      final_report();
   end

   initial
   begin
      #400000;
      error_cnt++;
      final_report();
   end
endmodule
